// File: verilog/aor_top.sv
// Accelerometer output register map: register core and link crossing
`timescale 1ns/1ns
`default_nettype none
module aor_top #(
  // Arbitrary identity value
  parameter logic [7:0] ID_VALUE = 8'h5A
) (
  // Core clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        ce,
  // Link clock and pins
  input  wire logic        link_clk,
  input  wire logic        scl_in,
  output logic             scl_out,
  output logic             scl_oe_b,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe_b,
  // Sensor and queue side
  input  wire logic        active,
  input  wire logic [7:0]  data_status,
  input  wire logic [7:0]  queue_status_in,
  input  wire logic [11:0] sample_x,
  input  wire logic [11:0] sample_y,
  input  wire logic [11:0] sample_z,
  input  wire logic [7:0]  highpass_x,
  input  wire logic [7:0]  highpass_y,
  input  wire logic [7:0]  highpass_z,
  input  wire logic [7:0]  operating_state,
  input  wire logic [7:0]  queue_narrow_data,
  input  wire logic [7:0]  queue_wide_data,
  // Queue control
  output logic             queue_pop_narrow,
  output logic             queue_pop_wide,
  output logic [7:0]       queue_setup
);

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    logic        req_seen;
    logic        ack;
    logic [7:0]  rdata;
    logic [7:0]  ptr;
    logic [7:0]  setup;
    logic [7:0]  dstat;
    logic [7:0]  qstat;
    logic [11:0] x;
    logic [11:0] y;
    logic [11:0] z;
    logic [7:0]  hx;
    logic [7:0]  hy;
    logic [7:0]  hz;
    logic [7:0]  opstate;
    logic        act_d;
    logic        pop_n;
    logic        pop_w;
  } aor_core_t;

  aor_core_t  r;
  aor_core_t  next_r;
  aor_xfer_if xf ();
  logic       req_s;
  logic       new_req;
  logic       queue_on;
  logic [7:0] status_now;
  logic [7:0] x_hi_now;

  // ************************************************************
  // Link engine and crossing
  // ************************************************************
  // Op and data are held by the link until the answer toggles back,
  // so only the toggle itself needs the synchroniser.
  aor_link u_link (
    .link_clk (link_clk),
    .rst_b    (rst_b),
    .scl_in   (scl_in),
    .sda_in   (sda_in),
    .scl_oe_b (scl_oe_b),
    .sda_oe_b (sda_oe_b),
    .pin_out  (scl_out),
    .xf       (xf.link)
  );

  assign sda_out = scl_out;

  aor_sync2 #(.W(1)) u_req_sync (
    .clk   (clk),
    .rst_b (rst_b),
    .ce    (ce),
    .d     (xf.req_tgl),
    .q     (req_s)
  );

  assign new_req    = (req_s != r.req_seen);
  assign queue_on   = |r.setup[aor_pkg::SETUP_MODE_HI:aor_pkg::SETUP_MODE_LO];
  assign status_now = queue_on ? r.qstat : r.dstat;
  assign x_hi_now   = r.x[11:4];

  // ************************************************************
  // Read decode
  // ************************************************************
  function automatic logic [7:0] rd_byte(input logic [7:0] a);
    logic [7:0] v;
    v = aor_pkg::RESET_BYTE;
    if (a == aor_pkg::A_STATUS0 || a == aor_pkg::A_STATUS1 ||
        a == aor_pkg::A_STATUS2) begin
      v = status_now;
    end else if (a == aor_pkg::A_XHI) begin
      v = queue_on ? queue_narrow_data : r.x[11:4];
    end else if (a == aor_pkg::A_YHI || a == aor_pkg::A_YHI_M) begin
      v = r.y[11:4];
    end else if (a == aor_pkg::A_ZHI || a == aor_pkg::A_ZHI_M) begin
      v = r.z[11:4];
    end else if (a == aor_pkg::A_XHI_M) begin
      v = r.x[11:4];
    end else if (a == aor_pkg::A_XLO) begin
      v = queue_on ? queue_wide_data : {aor_pkg::NIBBLE_ZERO, r.x[3:0]};
    end else if (a == aor_pkg::A_YLO) begin
      v = {aor_pkg::NIBBLE_ZERO, r.y[3:0]};
    end else if (a == aor_pkg::A_ZLO) begin
      v = {aor_pkg::NIBBLE_ZERO, r.z[3:0]};
    end else if (a == aor_pkg::A_HPX) begin
      v = r.hx;
    end else if (a == aor_pkg::A_HPY) begin
      v = r.hy;
    end else if (a == aor_pkg::A_HPZ) begin
      v = r.hz;
    end else if (a == aor_pkg::A_IDENT) begin
      v = ID_VALUE;
    end else if (a == aor_pkg::A_QSTAT) begin
      v = r.qstat;
    end else if (a == aor_pkg::A_QNARROW) begin
      v = queue_narrow_data;
    end else if (a == aor_pkg::A_QWIDE) begin
      v = queue_wide_data;
    end else if (a == aor_pkg::A_QSETUP) begin
      v = r.setup;
    end else if (a == aor_pkg::A_OPSTATE) begin
      v = r.opstate;
    end
    // Remaining addresses up to the top of the map belong to other
    // blocks and read as zero here; they still answer the host.
    return v;
  endfunction

  // ************************************************************
  // Auto-increment
  // ************************************************************
  function automatic logic [7:0] next_ptr(input logic [7:0] a);
    logic [7:0] p;
    p = a + 8'h01;
    if (a == aor_pkg::A_ZHI) begin
      p = aor_pkg::A_STATUS0;
    end else if (a == aor_pkg::A_ZHI_M) begin
      p = aor_pkg::A_STATUS1;
    end else if (a == aor_pkg::A_HPZ) begin
      p = aor_pkg::A_STATUS2;
    end else if (a == aor_pkg::A_XHI && queue_on) begin
      p = aor_pkg::A_XHI;
    end else if (a == aor_pkg::A_XLO && queue_on) begin
      p = aor_pkg::A_XLO;
    end else if (a == aor_pkg::A_QNARROW || a == aor_pkg::A_QWIDE) begin
      p = a;
    end else if (a == aor_pkg::A_LAST) begin
      p = aor_pkg::A_LAST_NX;
    end
    return p;
  endfunction

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    next_r       = r;
    next_r.pop_n = 1'b0;
    next_r.pop_w = 1'b0;
    next_r.act_d = active;
    if (active && !r.act_d) begin
      next_r.dstat   = aor_pkg::RESET_BYTE;
      next_r.qstat   = aor_pkg::RESET_BYTE;
      next_r.x       = '0;
      next_r.y       = '0;
      next_r.z       = '0;
      next_r.hx      = aor_pkg::RESET_BYTE;
      next_r.hy      = aor_pkg::RESET_BYTE;
      next_r.hz      = aor_pkg::RESET_BYTE;
      next_r.opstate = aor_pkg::RESET_BYTE;
    end else if (active) begin
      // Standby stops capture, so contents survive the transition
      next_r.dstat   = data_status;
      next_r.qstat   = queue_status_in;
      next_r.x       = sample_x;
      next_r.y       = sample_y;
      next_r.z       = sample_z;
      next_r.hx      = highpass_x;
      next_r.hy      = highpass_y;
      next_r.hz      = highpass_z;
      next_r.opstate = operating_state;
    end
    if (new_req) begin
      next_r.req_seen = req_s;
      next_r.ack      = ~r.ack;
      if (xf.op == aor_pkg::OP_PTR) begin
        next_r.ptr = xf.wdata;
      end else if (xf.op == aor_pkg::OP_WR) begin
        if (r.ptr == aor_pkg::A_QSETUP) begin
          next_r.setup = xf.wdata;
        end
        next_r.ptr = next_ptr(r.ptr);
      end else begin
        next_r.rdata = rd_byte(r.ptr);
        next_r.ptr   = next_ptr(r.ptr);
        next_r.pop_n = (r.ptr == aor_pkg::A_QNARROW) ||
                       (r.ptr == aor_pkg::A_XHI && queue_on);
        next_r.pop_w = (r.ptr == aor_pkg::A_QWIDE) ||
                       (r.ptr == aor_pkg::A_XLO && queue_on);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      r <= '0;
    end else if (ce) begin
      r <= next_r;
    end
  end

  assign xf.ack_tgl       = r.ack;
  assign xf.rdata         = r.rdata;
  assign queue_pop_narrow = r.pop_n;
  assign queue_pop_wide   = r.pop_w;
  assign queue_setup      = r.setup;

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_rd_at(logic [7:0] a);
    ce && new_req && (xf.op == aor_pkg::OP_RD) && (r.ptr == a);
  endsequence

  property p_range;
    s_rd_at(aor_pkg::A_LAST) |=> (r.ack != $past(r.ack));
  endproperty
  a_range: assert property (p_range)
    else $error("top address not answered");

  property p_alias;
    s_rd_at(aor_pkg::A_STATUS2) |=> (r.rdata == $past(status_now));
  endproperty
  a_alias: assert property (p_alias)
    else $error("status alias mismatch");

  property p_mirror;
    s_rd_at(aor_pkg::A_XHI_M) |=> (r.rdata == $past(x_hi_now));
  endproperty
  a_mirror: assert property (p_mirror)
    else $error("mirror high byte mismatch");

  property p_wrap8;
    s_rd_at(aor_pkg::A_ZHI) |=> (r.ptr == aor_pkg::A_STATUS0);
  endproperty
  a_wrap8: assert property (p_wrap8)
    else $error("narrow loop did not wrap");

  property p_wrap12;
    s_rd_at(aor_pkg::A_ZHI_M) |=> (r.ptr == aor_pkg::A_STATUS1);
  endproperty
  a_wrap12: assert property (p_wrap12)
    else $error("wide loop did not wrap");

  property p_wrapdelta;
    s_rd_at(aor_pkg::A_HPZ) |=> (r.ptr == aor_pkg::A_STATUS2);
  endproperty
  a_wrapdelta: assert property (p_wrapdelta)
    else $error("delta loop did not wrap");

  property p_root8;
    s_rd_at(aor_pkg::A_XHI) ##0 queue_on |=>
      (r.ptr == aor_pkg::A_XHI) && r.pop_n;
  endproperty
  a_root8: assert property (p_root8)
    else $error("narrow root pointer moved");

  property p_root12;
    s_rd_at(aor_pkg::A_XLO) ##0 queue_on |=>
      (r.ptr == aor_pkg::A_XLO) && r.pop_w;
  endproperty
  a_root12: assert property (p_root12)
    else $error("wide root pointer moved");

  property p_ident;
    s_rd_at(aor_pkg::A_IDENT) |=> (r.rdata == ID_VALUE);
  endproperty
  a_ident: assert property (p_ident)
    else $error("identity byte wrong");

  property p_window;
    s_rd_at(aor_pkg::A_QWIDE) |=> (r.ptr == aor_pkg::A_QWIDE) ##1
      (r.ptr == aor_pkg::A_QWIDE || $past(new_req));
  endproperty
  a_window: assert property (p_window)
    else $error("queue window pointer moved");

  property p_hold;
    (ce && !active && !r.act_d) |=> $stable(r.x) && $stable(r.dstat);
  endproperty
  a_hold: assert property (p_hold)
    else $error("standby lost register contents");

  property p_wake;
    (ce && active && !r.act_d) |=> (r.dstat == aor_pkg::RESET_BYTE) &&
      (r.qstat == aor_pkg::RESET_BYTE);
  endproperty
  a_wake: assert property (p_wake)
    else $error("volatile registers not cleared");

  property p_step;
    s_rd_at(aor_pkg::A_YLO) |=> (r.ptr == aor_pkg::A_YHI_M);
  endproperty
  a_step: assert property (p_step)
    else $error("pointer did not advance");

endmodule
`default_nettype wire

// File: verilog/aor_pkg.sv
// Constants and types shared by the accelerometer output register map
package aor_pkg;

  // ************************************************************
  // Register addresses
  // ************************************************************
  localparam logic [7:0] A_STATUS0 = 8'h00;
  localparam logic [7:0] A_XHI     = 8'h01;
  localparam logic [7:0] A_YHI     = 8'h02;
  localparam logic [7:0] A_ZHI     = 8'h03;
  localparam logic [7:0] A_STATUS1 = 8'h04;
  localparam logic [7:0] A_XLO     = 8'h05;
  localparam logic [7:0] A_XHI_M   = 8'h06;
  localparam logic [7:0] A_YLO     = 8'h07;
  localparam logic [7:0] A_YHI_M   = 8'h08;
  localparam logic [7:0] A_ZLO     = 8'h09;
  localparam logic [7:0] A_ZHI_M   = 8'h0A;
  localparam logic [7:0] A_STATUS2 = 8'h0B;
  localparam logic [7:0] A_HPX     = 8'h0C;
  localparam logic [7:0] A_HPY     = 8'h0D;
  localparam logic [7:0] A_HPZ     = 8'h0E;
  localparam logic [7:0] A_IDENT   = 8'h0F;
  localparam logic [7:0] A_QSTAT   = 8'h10;
  localparam logic [7:0] A_QNARROW = 8'h11;
  localparam logic [7:0] A_QWIDE   = 8'h12;
  localparam logic [7:0] A_QSETUP  = 8'h13;
  localparam logic [7:0] A_OPSTATE = 8'h14;
  localparam logic [7:0] A_LAST    = 8'h3F;
  localparam logic [7:0] A_LAST_NX = 8'h0F;

  // ************************************************************
  // Fields, reset values, link constants
  // ************************************************************
  localparam int         SETUP_MODE_HI = 7;
  localparam int         SETUP_MODE_LO = 6;
  localparam logic [7:0] RESET_BYTE    = 8'h00;
  localparam logic [3:0] NIBBLE_ZERO   = 4'h0;
  localparam logic [6:0] BUS_ADDR      = 7'h1D;
  localparam logic [1:0] OP_PTR        = 2'h1;
  localparam logic [1:0] OP_WR         = 2'h2;
  localparam logic [1:0] OP_RD         = 2'h3;
  localparam logic [3:0] BIT_LAST      = 4'h7;
  localparam logic [3:0] BIT_FULL      = 4'h8;
  localparam logic [1:0] IDX_DEV       = 2'h0;
  localparam logic [1:0] IDX_REG       = 2'h1;
  localparam logic [1:0] IDX_DATA      = 2'h2;

  typedef enum logic [5:0] {
    LS_IDLE = 6'h01,
    LS_RECV = 6'h02,
    LS_WAIT = 6'h04,
    LS_ACK  = 6'h08,
    LS_SEND = 6'h10,
    LS_MACK = 6'h20
  } aor_lstate_t;

endpackage

// File: verilog/aor_xfer_if.sv
// Handshake carrier between the serial link engine and the register core
`timescale 1ns/1ns
`default_nettype none
interface aor_xfer_if;
  logic       req_tgl;
  logic [1:0] op;
  logic [7:0] wdata;
  logic       ack_tgl;
  logic [7:0] rdata;
  modport link (output req_tgl, output op, output wdata,
                input ack_tgl, input rdata);
  modport core (input req_tgl, input op, input wdata,
                output ack_tgl, output rdata);
endinterface
`default_nettype wire

// File: verilog/aor_sync2.sv
// Two-flop level synchroniser with clock enable
`timescale 1ns/1ns
`default_nettype none
module aor_sync2 #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic         ce,
  // Data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } aor_sync_t;

  aor_sync_t r;
  aor_sync_t next_r;

  always_comb begin
    next_r    = r;
    next_r.s1 = d;
    next_r.s2 = r.s1;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      r <= '0;
    end else if (ce) begin
      r <= next_r;
    end
  end

  assign q = r.s2;
endmodule
`default_nettype wire

// File: verilog/aor_link.sv
// Serial register bus slave engine on the link clock
`timescale 1ns/1ns
`default_nettype none
module aor_link (
  // Link clock and reset
  input  wire logic  link_clk,
  input  wire logic  rst_b,
  // Open-drain pins
  input  wire logic  scl_in,
  input  wire logic  sda_in,
  output logic       scl_oe_b,
  output logic       sda_oe_b,
  output logic       pin_out,
  // Towards the register core
  aor_xfer_if.link   xf
);
  typedef struct packed {
    aor_pkg::aor_lstate_t st;
    logic [3:0]           bitc;
    logic [7:0]           shreg;
    logic                 rw;
    logic [1:0]           idx;
    logic                 more;
    logic                 to_send;
    logic                 req;
    logic [1:0]           op;
    logic [7:0]           wdata;
    logic                 scl_d;
    logic                 sda_d;
    logic                 scl_oe_b;
    logic                 sda_oe_b;
    logic                 pin_out;
  } aor_link_t;

  aor_link_t  r;
  aor_link_t  next_r;
  logic [2:0] sq;
  logic       scl, sda, done, rise, fall, start, stop;

  aor_sync2 #(.W(3)) u_pin_sync (
    .clk   (link_clk),
    .rst_b (rst_b),
    .ce    (1'b1),
    .d     ({scl_in, sda_in, xf.ack_tgl}),
    .q     (sq)
  );

  always_comb begin
    scl   = sq[2];
    sda   = sq[1];
    done  = (sq[0] == r.req);
    rise  = scl & ~r.scl_d;
    fall  = ~scl & r.scl_d;
    start = scl & r.scl_d & r.sda_d & ~sda;
    stop  = scl & r.scl_d & ~r.sda_d & sda;
    next_r       = r;
    next_r.scl_d = scl;
    next_r.sda_d = sda;
    if (stop) begin
      next_r.st       = aor_pkg::LS_IDLE;
      next_r.sda_oe_b = 1'b1;
    end else if (start) begin
      next_r.st       = aor_pkg::LS_RECV;
      next_r.bitc     = '0;
      next_r.idx      = aor_pkg::IDX_DEV;
      next_r.sda_oe_b = 1'b1;
    end else begin
      case (r.st)
        aor_pkg::LS_RECV: begin
          if (rise) begin
            next_r.shreg = {r.shreg[6:0], sda};
            next_r.bitc  = r.bitc + 4'h1;
          end else if (fall && r.bitc == aor_pkg::BIT_FULL) begin
            next_r.to_send = 1'b0;
            if (r.idx != aor_pkg::IDX_DEV) begin
              next_r.req      = ~r.req;
              next_r.op       = (r.idx == aor_pkg::IDX_REG) ?
                                aor_pkg::OP_PTR : aor_pkg::OP_WR;
              next_r.wdata    = r.shreg;
              next_r.st       = aor_pkg::LS_WAIT;
              next_r.scl_oe_b = 1'b0;
            end else if (r.shreg[7:1] != aor_pkg::BUS_ADDR) begin
              next_r.st = aor_pkg::LS_IDLE;
            end else if (r.shreg[0]) begin
              next_r.rw       = 1'b1;
              next_r.req      = ~r.req;
              next_r.op       = aor_pkg::OP_RD;
              next_r.st       = aor_pkg::LS_WAIT;
              next_r.scl_oe_b = 1'b0;
            end else begin
              next_r.rw       = 1'b0;
              next_r.st       = aor_pkg::LS_ACK;
              next_r.sda_oe_b = 1'b0;
            end
          end
        end
        // Clock held low until the core has answered
        aor_pkg::LS_WAIT: begin
          if (done) begin
            next_r.scl_oe_b = 1'b1;
            if (r.op == aor_pkg::OP_RD) begin
              next_r.shreg = xf.rdata;
            end
            if (r.to_send) begin
              next_r.st       = aor_pkg::LS_SEND;
              next_r.bitc     = '0;
              next_r.sda_oe_b = xf.rdata[7];
            end else begin
              next_r.st       = aor_pkg::LS_ACK;
              next_r.sda_oe_b = 1'b0;
            end
          end
        end
        aor_pkg::LS_ACK: begin
          if (fall) begin
            next_r.bitc = '0;
            if (r.rw) begin
              next_r.st       = aor_pkg::LS_SEND;
              next_r.sda_oe_b = r.shreg[7];
            end else begin
              next_r.st       = aor_pkg::LS_RECV;
              next_r.sda_oe_b = 1'b1;
              if (r.idx != aor_pkg::IDX_DATA) begin
                next_r.idx = r.idx + 2'h1;
              end
            end
          end
        end
        aor_pkg::LS_SEND: begin
          if (fall) begin
            if (r.bitc == aor_pkg::BIT_LAST) begin
              next_r.st       = aor_pkg::LS_MACK;
              next_r.sda_oe_b = 1'b1;
            end else begin
              next_r.shreg    = {r.shreg[6:0], 1'b0};
              next_r.sda_oe_b = r.shreg[6];
              next_r.bitc     = r.bitc + 4'h1;
            end
          end
        end
        // Master acknowledge fetches the next byte; a refusal ends it
        aor_pkg::LS_MACK: begin
          if (rise) begin
            next_r.more = ~sda;
          end else if (fall) begin
            if (r.more) begin
              next_r.req      = ~r.req;
              next_r.op       = aor_pkg::OP_RD;
              next_r.to_send  = 1'b1;
              next_r.st       = aor_pkg::LS_WAIT;
              next_r.scl_oe_b = 1'b0;
            end else begin
              next_r.st = aor_pkg::LS_IDLE;
            end
          end
        end
        default: begin
          next_r.st = aor_pkg::LS_IDLE;
        end
      endcase
    end
    next_r.pin_out = 1'b0;
  end

  always_ff @(posedge link_clk or negedge rst_b) begin
    if (!rst_b) begin
      r          <= '0;
      r.st       <= aor_pkg::LS_IDLE;
      r.scl_oe_b <= 1'b1;
      r.sda_oe_b <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign scl_oe_b   = r.scl_oe_b;
  assign sda_oe_b   = r.sda_oe_b;
  assign pin_out    = r.pin_out;
  assign xf.req_tgl = r.req;
  assign xf.op      = r.op;
  assign xf.wdata   = r.wdata;
endmodule
`default_nettype wire

// File: tb/aor_host.sv
// Host bus master model on the open-drain link pins
`timescale 1ns/1ns
`default_nettype none
module aor_host (
  // Pins
  input  wire logic scl,
  input  wire logic sda,
  output logic      scl_low,
  output logic      sda_low
);
  // **********
  // Bus cycles
  // **********
  localparam int H = 600;
  logic [7:0] rx;
  logic       ack;
  event       got;
  // Stretches that never end are counted as failures by the bench
  int         stuck = 0;
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  // Bounded wait, so a stretch that never ends cannot hang the run
  task automatic clk_hi();
    int n;
    scl_low = 1'b0;
    n = 0;
    while (scl !== 1'b1 && n < 4000) begin
      #10;
      n++;
    end
    if (n >= 4000) stuck++;
    #H;
  endtask
  task automatic bit_io(input logic b, output logic r);
    sda_low = !b;
    #H;
    clk_hi();
    r = sda;
    scl_low = 1'b1;
  endtask
  task automatic start();
    sda_low = 1'b0;
    #H;
    clk_hi();
    sda_low = 1'b1;
    #H;
    scl_low = 1'b1;
  endtask
  task automatic stop();
    sda_low = 1'b1;
    #H;
    clk_hi();
    sda_low = 1'b0;
    #H;
  endtask
  task automatic xfer(input logic [7:0] d, input logic last,
                      output logic [7:0] q);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], q[i]);
    end
    bit_io(last, ack);
  endtask
  // Write d when n is zero, else read n bytes
  task automatic acc(input logic [7:0] a, d, input int n);
    logic [7:0] q;
    start();
    xfer(8'h3A, 1'b1, q);
    xfer(a, 1'b1, q);
    if (n == 0) xfer(d, 1'b1, q);
    else start();
    if (n > 0) xfer(8'h3B, 1'b1, q);
    for (int i = 0; i < n; i++) begin
      xfer(8'hFF, i == n - 1, q);
      rx = q;
      -> got;
    end
    stop();
  endtask
endmodule
`default_nettype wire

// File: tb/aor_top_tb.sv
// Self-checking bench for the output register map
`timescale 1ns/1ns
`default_nettype none
module aor_top_tb;
  // *****
  // Bench
  // *****
  localparam logic [7:0] ID = 8'hA5; // Arbitrary identity value
  logic        clk = 1'b0, link_clk = 1'b0, rst_b = 1'b0, active = 1'b0;
  logic [7:0]  dst, qst, hx, hy, hz, ost, qn, qw, qs, o, b;
  logic [11:0] sx, sy, sz;
  logic        scl_oe_b, sda_oe_b, pn, pw, h_scl, h_sda, pin_s, pin_d;
  logic        ce = 1'b1;
  wire         scl = !(h_scl | !scl_oe_b);
  wire         sda = !(h_sda | !sda_oe_b);
  integer      seed = 32'h0F14;
  int          n_fail = 0, num_checks = 0, np = 0, nw = 0;
  logic [7:0]  exp_q[$];
  aor_top #(.ID_VALUE(ID)) dut (
    .clk(clk), .rst_b(rst_b), .ce(ce), .link_clk(link_clk),
    .scl_in(scl), .scl_out(pin_s), .scl_oe_b(scl_oe_b), .sda_in(sda),
    .sda_out(pin_d), .sda_oe_b(sda_oe_b), .active(active),
    .data_status(dst), .queue_status_in(qst), .sample_x(sx),
    .sample_y(sy), .sample_z(sz), .highpass_x(hx), .highpass_y(hy),
    .highpass_z(hz), .operating_state(ost), .queue_narrow_data(qn),
    .queue_wide_data(qw), .queue_pop_narrow(pn), .queue_pop_wide(pw),
    .queue_setup(qs));
  aor_host host (.scl(scl), .sda(sda), .scl_low(h_scl), .sda_low(h_sda));
  initial forever #10 clk = ~clk;
  // Enable low one cycle in four freezes the core
  always @(negedge clk) ce <= (($random(seed) & 32'h3) != 32'h0);
  initial forever begin
    #62 link_clk = ~link_clk;
    #63 link_clk = ~link_clk;
  end
  always @(posedge clk) begin
    // A pop held over frozen cycles counts once
    np += (pn === 1'b1 && ce === 1'b1);
    nw += (pw === 1'b1 && ce === 1'b1);
  end
  task automatic chk(input string s, input logic [7:0] e, g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic rnd();
    logic [127:0] r;
    r = {$random(seed), $random(seed), $random(seed), $random(seed)};
    @(negedge clk);
    {dst, qst, hx, hy, hz, ost, qn, qw, sx, sy, sz} = r[99:0];
    repeat (4) @(negedge clk);
  endtask
  task automatic rd(input logic [7:0] a);
    host.acc(a, 8'h00, exp_q.size());
  endtask
  task automatic complete_run();
    n_fail += host.stuck;
    $display("checks %0d fails %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial forever begin
    @(host.got);
    chk("rdata", exp_q.pop_front(), host.rx);
  end
  initial begin
    #1800000;
    n_fail++;
    complete_run();
  end
  initial begin
    {dst, qst, hx, hy, hz, ost, qn, qw, sx, sy, sz} = '0;
    repeat (12) @(negedge clk);
    rst_b = 1'b1;
    rnd();
    repeat (40) @(negedge clk);
    exp_q = {ID, 8'h00};
    rd(8'h0F);
    exp_q = {8'h00};
    rd(8'h00);
    @(negedge clk) active = 1'b1;
    rnd();
    exp_q = {dst, sx[11:4], sy[11:4], sz[11:4], dst};
    rd(8'h00);
    exp_q = {dst, 8'(sx[3:0]), sx[11:4], 8'(sy[3:0]), sy[11:4],
             8'(sz[3:0]), sz[11:4], dst};
    rd(8'h04);
    exp_q = {dst, hx, hy, hz, dst};
    rd(8'h0B);
    host.acc(8'h0F, ~ID, 0);
    exp_q = {ID, qst, qn, qn};
    rd(8'h0F);
    host.acc(8'h13, 8'h40, 0);
    exp_q = {qst, qn, qn};
    rd(8'h00);
    exp_q = {qw, qw};
    rd(8'h05);
    exp_q = {qw, qw};
    rd(8'h12);
    exp_q = {8'h40, ost, 8'h00};
    rd(8'h13);
    exp_q = {8'h00, ID};
    rd(8'h3F);
    chk("setup", 8'h40, qs);
    chk("pops", 8'h44, {np[3:0], nw[3:0]});
    chk("drive", 8'h00, 8'({pin_s, pin_d}));
    @(negedge clk) active = 1'b0;
    o = qst;
    rnd();
    exp_q = {o};
    rd(8'h10);
    host.start();
    host.xfer(8'h3C, 1'b1, b);
    host.stop();
    chk("nak", 8'h01, 8'(host.ack));
    complete_run();
  end
endmodule
`default_nettype wire
